// [logic/mc_log_cfg.svh]
// register offsets, field positions, masks and reset values for the error logger
`ifndef MC_LOG_CFG_SVH
`define MC_LOG_CFG_SVH

`define APB_ADDR_W        12
`define OFS_STATUS_LOW    12'h048
`define OFS_STATUS_HIGH   12'h04C
`define OFS_ADDR_LOW      12'h050
`define OFS_ADDR_HIGH     12'h054
`define OFS_LOG_CTRL      12'h058

`define ST_CORE0          0
`define ST_CORE1          1
`define ST_LINK_LO        4
`define ST_LINK_HI        6
`define ST_SCRUB          8
`define ST_CHAN           9
`define ST_MULTI          13
`define ST_SINGLE         14
`define ST_SYN_LO         15
`define ST_SYN_HI         22
`define ST_PCC            25
`define ST_ADDRV          26
`define ST_MISCV          27
`define ST_EN             28
`define ST_UNCORR         29
`define ST_OVER           30
`define ST_VALID          31

`define SL_SYN_LO         24
`define SL_SYN_HI         31
`define AL_ADDR_LO        3
`define AH_ADDR_HI        7

`define STATUS_WMASK      32'hF67F_E373
`define STATUS_RMASK      32'hFE7F_E373
`define STLOW_MASK        32'hFF00_0000
`define ADDRLO_MASK       32'hFFFF_FFF8
`define ADDRHI_MASK       32'h0000_00FF
`define CTRL_MASK         32'h0000_0003
`define CTRL_REPORT_BIT   0
`define CTRL_COUNT_BIT    1
`define CTRL_RESET        2'h0
`define ZERO_WORD         32'h0000_0000

`endif

// [logic/mc_log_pkg.sv]
// types shared by the error logger modules
package mc_log_pkg;

  // kind of error reported by the system-interface unit
  typedef enum logic [3:0] {
    ERR_ECC,
    ERR_CRC,
    ERR_SYNC,
    ERR_MST_ABORT,
    ERR_TGT_ABORT,
    ERR_GART,
    ERR_RMW,
    ERR_WDOG,
    ERR_SYMBOL_ECC,
    ERR_DEV,
    ERR_PARITY
  } err_kind_t;

endpackage

// [logic/err_class_if.sv]
// error kind in, per-kind status settings out
`timescale 1ns/100ps
interface err_class_if;
  import mc_log_pkg::*;

  err_kind_t kind;          // kind of incoming error
  logic      multiBit;      // ecc error spans more than one bit or symbol
  logic      coreSource;    // request was sourced by a core
  logic      notCorrected;  // status uncorrected value
  logic      addrValid;     // address word is meaningful
  logic      ctxCorrupt;    // processor context may be corrupt
  logic      syndValid;     // syndrome is captured
  logic      singleFix;     // correctable ecc
  logic      multiFail;     // uncorrectable ecc
  logic      linkValid;     // link number is meaningful
  logic      coreValid;     // core flags are meaningful
  logic      isEcc;         // either ecc kind
  logic      isParity;      // memory parity error

  modport logger (output kind, multiBit, coreSource,
                  input notCorrected, addrValid, ctxCorrupt, syndValid, singleFix,
                  multiFail, linkValid, coreValid, isEcc, isParity);
  modport classifier (input kind, multiBit, coreSource,
                      output notCorrected, addrValid, ctxCorrupt, syndValid, singleFix,
                      multiFail, linkValid, coreValid, isEcc, isParity);
endinterface

// [logic/error_classifier.sv]
// decodes an error kind into the status settings it must log
`timescale 1ns/100ps
`include "mc_log_cfg.svh"
module error_classifier
  import mc_log_pkg::*;
(
  err_class_if.classifier cls
);

  // per-kind status table
  always_comb begin
    cls.notCorrected = 1'b1;
    cls.addrValid    = 1'b0;
    cls.ctxCorrupt   = 1'b1;
    cls.syndValid    = 1'b0;
    cls.singleFix    = 1'b0;
    cls.multiFail    = 1'b0;
    cls.linkValid    = 1'b0;
    cls.coreValid    = 1'b0;
    cls.isEcc        = 1'b0;
    cls.isParity     = 1'b0;
    unique case (cls.kind)
      // bit or symbol ecc: fault class follows the width of the error
      ERR_ECC, ERR_SYMBOL_ECC: begin
        cls.notCorrected = cls.multiBit;
        cls.addrValid    = 1'b1;
        cls.ctxCorrupt   = cls.multiBit & cls.coreSource;
        cls.syndValid    = 1'b1;
        cls.singleFix    = ~cls.multiBit;
        cls.multiFail    = cls.multiBit;
        cls.coreValid    = 1'b1;
        cls.isEcc        = 1'b1;
      end
      // link errors carry no address
      ERR_CRC, ERR_SYNC: begin
        cls.linkValid = 1'b1;
      end
      // aborts keep the address and the link
      ERR_MST_ABORT, ERR_TGT_ABORT: begin
        cls.addrValid  = 1'b1;
        cls.ctxCorrupt = cls.coreSource;
        cls.linkValid  = 1'b1;
        cls.coreValid  = 1'b1;
      end
      // table walk error keeps the address but no link
      ERR_GART: begin
        cls.addrValid  = 1'b1;
        cls.ctxCorrupt = cls.coreSource;
        cls.coreValid  = 1'b1;
      end
      // read-modify-write and exclusion errors keep state intact
      ERR_RMW, ERR_DEV: begin
        cls.addrValid  = 1'b1;
        cls.ctxCorrupt = 1'b0;
        cls.linkValid  = 1'b1;
      end
      // parity error names the channel
      ERR_PARITY: begin
        cls.isParity = 1'b1;
      end
      // watchdog keeps the defaults
      ERR_WDOG: begin
        cls.isParity = 1'b0;
      end
      default: begin
        cls.notCorrected = 1'b1;
      end
    endcase
  end

endmodule

// [logic/machine_check_status_logger.sv]
// machine-check error logger with apb register access
//
// Summary of operation
// - bit 0 flags core 0 errors
// - bit 1 flags core 1 errors
// - bits 6-4 hold one-hot link number
// - bit 8 marks scrubber-found errors
// - bit 9 gives parity error channel
// - bit 13 marks uncorrectable ecc
// - bit 14 marks corrected ecc
// - bits 22-15 hold low syndrome byte
// - bit 25 marks possibly corrupt context
// - bit 26 marks address word valid
// - bit 27 set for counted ecc errors
// - bit 28 holds reporting enable at capture
// - bit 29 marks error not corrected
// - bit 30 set on error while valid
// - overwrite priority never displaces uncorrectable
// - bit 31 marks a logged error
// - log fields undefined after reset
// - ecc kinds set fields by width
// - link, abort and table errors fields
// - watchdog, parity, rmw, exclusion fields
// - address bits 31-3 in low word
// - upper syndrome byte in companion word
// - address bits 39-32 in high word
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`include "mc_log_cfg.svh"
module machine_check_status_logger
  import mc_log_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   errStrobe,
  input  wire err_kind_t              errKind,
  input  wire logic                   errMultiBit,
  input  wire logic                   errCoreSource,
  input  wire logic                   errCore0,
  input  wire logic                   errCore1,
  input  wire logic [2:0]             errLink,
  input  wire logic                   scrubber_found,
  input  wire logic                   errChannel,
  input  wire logic [15:0]            errSyndrome,
  input  wire logic [39:0]            errAddress
);

  err_class_if cls ();                  // kind decode carrier

  logic [31:0] statusReg;               // status high word
  logic [31:0] statusLowReg;            // companion word, upper syndrome
  logic [31:0] addrLowReg;              // fault_address_low
  logic [31:0] addrHighReg;             // fault_address_high
  logic [1:0]  ctrlReg;                 // reporting_on and error_counter_on sources
  logic [31:0] newStatus;               // record built from the incoming error
  logic        takeNew;                 // incoming error replaces the record
  logic        overflowHit;             // incoming error found a valid record
  logic        setupRd;                 // apb read setup cycle
  logic        accWr;                   // apb write access cycle
  logic        mapped;                  // address hits a register
  logic        reportOn;                // machine-check reporting enabled
  logic        counterOn;               // error counter enabled

  assign cls.kind       = errKind;
  assign cls.coreSource = errCoreSource;
  assign cls.multiBit   = errMultiBit;
  assign reportOn       = ctrlReg[`CTRL_REPORT_BIT];
  assign counterOn      = ctrlReg[`CTRL_COUNT_BIT];

  // per-kind decode
  error_classifier u_classifier (
    .cls (cls)
  );

  // address decode, shared by read and write paths
  function automatic logic hit(input logic [`APB_ADDR_W-1:0] a);
    hit = (a == `OFS_STATUS_LOW) || (a == `OFS_STATUS_HIGH) || (a == `OFS_ADDR_LOW) ||
          (a == `OFS_ADDR_HIGH) || (a == `OFS_LOG_CTRL);
  endfunction

  assign mapped  = hit(paddr);
  assign setupRd = psel & ~penable & ~pwrite;
  assign accWr   = psel & penable & pwrite & mapped;
  // the bus never stalls: one setup and one access cycle per transfer
  assign pready  = 1'b1;                               // zero wait states
  assign pslverr = psel & penable & ~mapped;           // unmapped address

  // assemble the record for the incoming error
  always_comb begin
    newStatus                                = `ZERO_WORD;
    newStatus[`ST_VALID]                     = 1'b1;
    newStatus[`ST_UNCORR]                    = cls.notCorrected;
    newStatus[`ST_EN]                        = reportOn;
    newStatus[`ST_MISCV]                     = counterOn & cls.isEcc;
    newStatus[`ST_ADDRV]                     = cls.addrValid;
    newStatus[`ST_PCC]                       = cls.ctxCorrupt;
    newStatus[`ST_SINGLE]                    = cls.singleFix;
    newStatus[`ST_MULTI]                     = cls.multiFail;
    newStatus[`ST_SCRUB]                     = cls.isEcc & scrubber_found;
    newStatus[`ST_CHAN]                      = cls.isParity & errChannel;
    newStatus[`ST_CORE0]                     = cls.coreValid & errCore0;
    newStatus[`ST_CORE1]                     = cls.coreValid & errCore1;
    // one-hot link number only where the kind names a link
    if (cls.linkValid) begin
      newStatus[`ST_LINK_HI:`ST_LINK_LO]     = errLink;
    end
    // lower syndrome byte for ecc kinds
    if (cls.syndValid) begin
      newStatus[`ST_SYN_HI:`ST_SYN_LO]       = errSyndrome[7:0];
    end
  end

  // overwrite priority against the record already held
  always_comb begin
    overflowHit = errStrobe & statusReg[`ST_VALID];
    if (!errStrobe) begin
      takeNew = 1'b0;
    end else if (!statusReg[`ST_VALID]) begin
      takeNew = 1'b1;                                  // empty log always fills
    end else if (statusReg[`ST_UNCORR]) begin
      takeNew = 1'b0;                                  // uncorrectable record is kept
    end else if (cls.notCorrected) begin
      takeNew = 1'b1;                                  // uncorrectable over correctable
    end else begin
      takeNew = ~statusReg[`ST_EN] & reportOn;         // enabled over disabled
    end
  end

  // status high word: no reset, hardware logging beats a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (takeNew) begin
      statusReg <= newStatus;
      statusReg[`ST_OVER] <= overflowHit;
    end else if (overflowHit) begin
      statusReg[`ST_OVER] <= 1'b1;
    end else if (accWr && paddr == `OFS_STATUS_HIGH) begin
      // misc-valid is read-only, reserved bits stay zero
      statusReg <= (pwdata & `STATUS_WMASK) | (statusReg & ~`STATUS_WMASK);
    end
  end

  // companion word: upper syndrome in symbol mode
  always_ff @(posedge clk_sys) begin
    if (takeNew) begin
      statusLowReg <= `ZERO_WORD;
      if (errKind == ERR_SYMBOL_ECC) begin
        statusLowReg[`SL_SYN_HI:`SL_SYN_LO] <= errSyndrome[15:8];
      end
    end else if (accWr && !errStrobe && paddr == `OFS_STATUS_LOW) begin
      // a write beside a reported error is dropped, as in the status word
      statusLowReg <= pwdata & `STLOW_MASK;
    end
  end

  // fault address words, captured with every accepted record
  always_ff @(posedge clk_sys) begin
    if (takeNew) begin
      addrLowReg  <= {errAddress[31:`AL_ADDR_LO], 3'h0};
      addrHighReg <= {24'h00_0000, errAddress[39:32]};
    end else if (accWr && !errStrobe && paddr == `OFS_ADDR_LOW) begin
      // a reported error keeps its address over a same-cycle software write
      addrLowReg  <= pwdata & `ADDRLO_MASK;
    end else if (accWr && !errStrobe && paddr == `OFS_ADDR_HIGH) begin
      addrHighReg <= pwdata & `ADDRHI_MASK;
    end
  end

  // control word: reporting and counter enables, defined after reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrlReg <= `CTRL_RESET;
    end else if (accWr && paddr == `OFS_LOG_CTRL) begin
      ctrlReg <= pwdata[1:0];
    end
  end

  // read data registered in the setup cycle, valid through the access cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= `ZERO_WORD;
    end else if (setupRd) begin
      unique case (paddr)
        `OFS_STATUS_LOW:  prdata <= statusLowReg & `STLOW_MASK;
        `OFS_STATUS_HIGH: prdata <= statusReg & `STATUS_RMASK;
        `OFS_ADDR_LOW:    prdata <= addrLowReg & `ADDRLO_MASK;
        `OFS_ADDR_HIGH:   prdata <= addrHighReg & `ADDRHI_MASK;
        `OFS_LOG_CTRL:    prdata <= {30'h0000_0000, ctrlReg};
        default:          prdata <= `ZERO_WORD;
      endcase
    end
  end

  // ---- assertions ----

  // any error leaves a valid record
  a_valid_after_error: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    errStrobe |=> statusReg[`ST_VALID])
    else $error("valid flag not set after an error");

  // a second error while valid raises overflow in the next cycle
  a_overflow_raise: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (errStrobe && statusReg[`ST_VALID]) |=> statusReg[`ST_OVER])
    else $error("overflow not raised on error while valid");

  // an uncorrectable record survives later errors
  a_uncorr_kept: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (errStrobe && statusReg[`ST_VALID] && statusReg[`ST_UNCORR])
    |=> (statusReg[29:0] == {1'b1, $past(statusReg[28:0])}) &&
        (addrLowReg == $past(addrLowReg)))
    else $error("uncorrectable record was overwritten");

  // uncorrectable error replaces a correctable record
  a_uncorr_wins: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (errStrobe && statusReg[`ST_VALID] && !statusReg[`ST_UNCORR] && cls.notCorrected)
    |=> statusReg[`ST_UNCORR] && statusReg[`ST_OVER])
    else $error("uncorrectable error did not replace correctable record");

  // captured ecc syndrome matches the error
  a_ecc_syndrome: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && errKind == ERR_ECC)
    |=> statusReg[`ST_SYN_HI:`ST_SYN_LO] == $past(errSyndrome[7:0]) &&
        statusReg[`ST_MULTI] == $past(errMultiBit) &&
        statusReg[`ST_SINGLE] == !$past(errMultiBit))
    else $error("ecc syndrome or class mislogged");

  // enable and misc-valid follow the control word at capture
  a_enable_mirror: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    takeNew |=> statusReg[`ST_EN] == $past(ctrlReg[`CTRL_REPORT_BIT]) &&
                statusReg[`ST_MISCV] == ($past(ctrlReg[`CTRL_COUNT_BIT]) && $past(cls.isEcc)))
    else $error("enable or misc-valid mislogged");

  // link errors log a link, no address and corrupt context
  a_link_fields: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && (errKind == ERR_CRC || errKind == ERR_SYNC))
    |=> statusReg[`ST_LINK_HI:`ST_LINK_LO] == $past(errLink) &&
        !statusReg[`ST_ADDRV] && statusReg[`ST_PCC] && statusReg[`ST_UNCORR])
    else $error("link error fields mislogged");

  // fault address lands in both address words
  a_address_capture: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    takeNew |=> addrLowReg == {$past(errAddress[31:3]), 3'h0} &&
                addrHighReg[7:0] == $past(errAddress[39:32]))
    else $error("fault address mislogged");

  // reserved bits of the status word read as zero
  a_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (setupRd && paddr == `OFS_STATUS_HIGH) |=> (prdata & ~`STATUS_RMASK) == `ZERO_WORD)
    else $error("reserved status bits read nonzero");

  // parity error names the channel and no core
  a_parity_channel: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && errKind == ERR_PARITY)
    |=> statusReg[`ST_CHAN] == $past(errChannel) && !statusReg[`ST_ADDRV] &&
        statusReg[1:0] == 2'h0)
    else $error("parity error fields mislogged");

  // ecc errors log their core flags
  a_core_flags: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && errKind == ERR_ECC)
    |=> statusReg[`ST_CORE0] == $past(errCore0) && statusReg[`ST_CORE1] == $past(errCore1))
    else $error("core flags mislogged");

  // scrubber flag follows the ecc report
  a_scrub_flag: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && errKind == ERR_ECC) |=> statusReg[`ST_SCRUB] == $past(scrubber_found))
    else $error("scrubber flag mislogged");

  // bit and symbol ecc class follows the error width
  a_ecc_class: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && (errKind == ERR_ECC || errKind == ERR_SYMBOL_ECC))
    |=> statusReg[`ST_ADDRV] && statusReg[`ST_UNCORR] == $past(errMultiBit) &&
        statusReg[`ST_PCC] == $past(errMultiBit && errCoreSource))
    else $error("ecc fields mislogged");

  // symbol mode keeps the upper syndrome byte
  a_symbol_syndrome: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && errKind == ERR_SYMBOL_ECC)
    |=> statusLowReg[`SL_SYN_HI:`SL_SYN_LO] == $past(errSyndrome[15:8]))
    else $error("upper syndrome mislogged");

  // watchdog and parity log no address and no link
  a_wdog_fields: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && (errKind == ERR_WDOG || errKind == ERR_PARITY))
    |=> statusReg[`ST_UNCORR] && !statusReg[`ST_ADDRV] && statusReg[`ST_PCC] &&
        statusReg[`ST_LINK_HI:`ST_LINK_LO] == 3'h0)
    else $error("watchdog or parity fields mislogged");

  // rmw and exclusion errors keep context and log address and link
  a_rmw_fields: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && (errKind == ERR_RMW || errKind == ERR_DEV))
    |=> !statusReg[`ST_PCC] && statusReg[`ST_ADDRV] &&
        statusReg[`ST_LINK_HI:`ST_LINK_LO] == $past(errLink))
    else $error("rmw or exclusion fields mislogged");

  // aborts and table walk errors corrupt context only for core requests
  a_abort_fields: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (takeNew && (errKind == ERR_MST_ABORT || errKind == ERR_TGT_ABORT || errKind == ERR_GART))
    |=> statusReg[`ST_UNCORR] && statusReg[`ST_ADDRV] &&
        statusReg[`ST_PCC] == $past(errCoreSource))
    else $error("abort fields mislogged");

  // a software write lands in the address word
  a_write_lands: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (accWr && !errStrobe && paddr == `OFS_ADDR_LOW)
    |=> addrLowReg == ($past(pwdata) & `ADDRLO_MASK))
    else $error("address write lost");

  // reserved address bits read as zero
  a_addr_reserved: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    (setupRd && paddr == `OFS_ADDR_LOW) |=> prdata[`AL_ADDR_LO-1:0] == 3'h0)
    else $error("reserved address bits read nonzero");

endmodule

// [verification/machine_check_status_logger_bench.sv]
// self-checking bench for the machine-check error logger
`timescale 1ns/100ps
`include "mc_log_cfg.svh"
module machine_check_status_logger_bench
  import mc_log_pkg::*;
;
  logic                   clk_sys;        // 200 MHz system clock
  logic                   reset_n;        // async reset, active low
  logic                   psel;           // apb select
  logic                   penable;        // apb access phase
  logic                   pwrite;         // apb direction
  logic [`APB_ADDR_W-1:0] paddr;          // apb byte address
  logic [31:0]            pwdata;         // apb write data
  logic [31:0]            prdata;         // apb read data
  logic                   pready;         // apb ready
  logic                   pslverr;        // apb error
  logic                   errStrobe;      // one-cycle error report
  err_kind_t              errKind;        // kind of reported error
  logic                   errMultiBit;    // multi-bit ecc
  logic                   errCoreSource;  // core sourced the request
  logic                   errCore0;       // core 0 association
  logic                   errCore1;       // core 1 association
  logic [2:0]             errLink;        // one-hot link
  logic                   scrubber_found;       // found by scrubber
  logic                   errChannel;     // parity channel
  logic [15:0]            errSyndrome;    // ecc syndrome
  logic [39:0]            errAddress;     // failing address
  int                     badCount;       // mismatches seen
  int                     samplesChecked; // comparisons made
  int                     cycleCount;     // cycles since start
  logic [31:0]            rd;             // last read data
  logic                   rerr;           // last read error flag
  err_kind_t              kinds [8];      // table of non-ecc kinds
  logic                   srcs [8];       // core-source flag per kind
  logic [31:0]            expects [8];    // expected status per kind

  machine_check_status_logger dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .errStrobe(errStrobe), .errKind(errKind),
    .errMultiBit(errMultiBit), .errCoreSource(errCoreSource), .errCore0(errCore0),
    .errCore1(errCore1), .errLink(errLink), .scrubber_found(scrubber_found), .errChannel(errChannel),
    .errSyndrome(errSyndrome), .errAddress(errAddress));

  // clock generator
  always #2.5 clk_sys = ~clk_sys;

  // hang guard: a run this long means a wait never ended
  always @(posedge clk_sys) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 5000) begin
      badCount = badCount + 1;
      completeRun();
    end
  end

  // verdict and end of run
  task automatic completeRun();
    if (badCount == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked = samplesChecked + 1;
    if (seen !== exp) begin
      badCount = badCount + 1;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apbXfer(input logic wr, input logic [`APB_ADDR_W-1:0] a,
                         input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [`APB_ADDR_W-1:0] a, input logic [31:0] d);
    apbXfer(1'b1, a, d, rd, rerr);
  endtask

  // register read compared with an expected word
  task automatic rdChk(input logic [`APB_ADDR_W-1:0] a, input logic [31:0] exp);
    apbXfer(1'b0, a, 32'h0000_0000, rd, rerr);
    check(rd, exp);
  endtask

  // report one error for a single cycle
  task automatic inject(input err_kind_t k, input logic mb, input logic src,
                        input logic c0, input logic c1, input logic [2:0] lk,
                        input logic sc, input logic ch, input logic [15:0] sy);
    @(posedge clk_sys);
    errStrobe     <= 1'b1;
    errKind       <= k;
    errMultiBit   <= mb;
    errCoreSource <= src;
    errCore0      <= c0;
    errCore1      <= c1;
    errLink       <= lk;
    scrubber_found      <= sc;
    errChannel    <= ch;
    errSyndrome   <= sy;
    @(posedge clk_sys);
    errStrobe     <= 1'b0;
  endtask

  // main sequence
  initial begin
    clk_sys = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; errStrobe = 1'b0; errKind = ERR_ECC;
    errMultiBit = 1'b0; errCoreSource = 1'b0; errCore0 = 1'b0; errCore1 = 1'b0;
    errLink = 3'h0; scrubber_found = 1'b0; errChannel = 1'b0; errSyndrome = 16'h0000;
    errAddress = 40'hAB_1234_567F; badCount = 0; samplesChecked = 0; cycleCount = 0;
    kinds   = '{ERR_WDOG, ERR_PARITY, ERR_RMW, ERR_DEV, ERR_MST_ABORT, ERR_TGT_ABORT,
                ERR_GART, ERR_SYNC};
    srcs    = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    expects = '{32'hA200_0000, 32'hA200_0200, 32'hA400_0020, 32'hA400_0020,
                32'hA600_0021, 32'hA400_0021, 32'hA600_0001, 32'hA200_0020};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdChk(`OFS_LOG_CTRL, 32'h0000_0000);
    apbXfer(1'b0, 12'h0F0, 32'h0000_0000, rd, rerr);
    check({31'h0, rerr}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    // seed a clean log, then a counted, reported correctable ecc error
    wr(`OFS_STATUS_HIGH, 32'h0000_0000);
    wr(`OFS_LOG_CTRL, 32'h0000_0003);
    inject(ERR_ECC, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0, 16'h1234);
    rdChk(`OFS_STATUS_HIGH, 32'h9C1A_4101);
    rdChk(`OFS_ADDR_LOW, 32'h1234_5678);
    rdChk(`OFS_ADDR_HIGH, 32'h0000_00AB);
    rdChk(`OFS_STATUS_LOW, 32'h0000_0000);
    // uncorrectable link error displaces the correctable record
    inject(ERR_CRC, 1'b0, 1'b0, 1'b0, 1'b0, 3'h4, 1'b0, 1'b0, 16'h0000);
    rdChk(`OFS_STATUS_HIGH, 32'hF200_0040);
    inject(ERR_ECC, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0055);
    rdChk(`OFS_STATUS_HIGH, 32'hF200_0040);
    // software writes: reserved and read-only bits stay zero
    wr(`OFS_STATUS_HIGH, 32'hFFFF_FFFF);
    rdChk(`OFS_STATUS_HIGH, 32'hF67F_E373);
    wr(`OFS_ADDR_LOW, 32'hFFFF_FFFF);
    rdChk(`OFS_ADDR_LOW, 32'hFFFF_FFF8);
    wr(`OFS_STATUS_HIGH, 32'h0000_0000);
    rdChk(`OFS_STATUS_HIGH, 32'h0000_0000);
    // multi-symbol ecc from core 1, reporting on, counting off
    wr(`OFS_LOG_CTRL, 32'h0000_0001);
    inject(ERR_SYMBOL_ECC, 1'b1, 1'b1, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0, 16'hBEEF);
    rdChk(`OFS_STATUS_HIGH, 32'hB677_A002);
    rdChk(`OFS_STATUS_LOW, 32'hBE00_0000);
    // disabled correctable record is replaced by an enabled one
    wr(`OFS_STATUS_HIGH, 32'h0000_0000);
    wr(`OFS_LOG_CTRL, 32'h0000_0000);
    inject(ERR_ECC, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0011);
    rdChk(`OFS_STATUS_HIGH, 32'h8408_C000);
    wr(`OFS_LOG_CTRL, 32'h0000_0001);
    inject(ERR_ECC, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0022);
    rdChk(`OFS_STATUS_HIGH, 32'hD411_4000);
    inject(ERR_ECC, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 16'h0033);
    rdChk(`OFS_STATUS_HIGH, 32'hD411_4000);
    // every other error kind from a clean log with reporting off
    wr(`OFS_LOG_CTRL, 32'h0000_0000);
    errAddress <= 40'h12_8765_4321;
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_STATUS_HIGH, 32'h0000_0000);
      inject(kinds[i], 1'b0, srcs[i], 1'b1, 1'b0, 3'h2, 1'b1, 1'b1, 16'h0000);
      rdChk(`OFS_STATUS_HIGH, expects[i]);
    end
    rdChk(`OFS_ADDR_LOW, 32'h8765_4320);
    rdChk(`OFS_ADDR_HIGH, 32'h0000_0012);
    completeRun();
  end
endmodule
